// ---- mmap_decoder.sv ----
// Memory map decoder and stack control for a 4-bit core
`timescale 1ns/10ps
`include "mmap_params.svh"

// Behaviour
// - After reset or interrupt acknowledge, fetch comes from ROM vector region.
// - Short subroutine branch targets only zero-page subroutine region.
// - Table fetch reads any location of the pattern region.
// - Entire implemented ROM is program space; top set per variant.
// - Data RAM holds 384 or 512 four-bit digits by variant.
// - Lowest RAM addresses decode to the register-mapped overlay region.
// - Interrupt control bits only take bit set, clear and test.
// - Special function registers refuse bit manipulation operations.
// - Register flag range only takes bit set, clear and test.
// - Sixteen scratch registers reached by scratch load and swap.
// - General data starts above scratch area, ends at variant top.
// - Calls and interrupt entry save PC, condition and overflow bits.
// - Sixteen stack levels, four digits each.
// - Both returns restore PC; interrupt return also restores flags.
// - Unused stack locations act as ordinary data RAM.
// - Halt wake input leaves stop mode for active operation.
// - Stack index resets to top, moves by four, top nibble ones.
module mmap_decoder
	import mmap_pkg::*;
#(
	parameter logic [13:0] ROM_TOP  = `ROM_TOP_DEFAULT,
	parameter logic [9:0]  DATA_TOP = `RAM_DATA_TOP_DEF
)(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RESETN,
	// Core requests
	input  wire logic        FETCH,
	input  wire logic [13:0] FETCH_ADDR,
	input  wire logic        SHORT_CALL,
	input  wire logic        IRQ_ACK,
	input  wire logic        TABLE_RD,
	input  wire logic [13:0] TABLE_ADDR,
	input  wire logic        RAM_REQ,
	input  wire logic        RAM_WR,
	input  wire access_e     RAM_KIND,
	input  wire logic [9:0]  RAM_ADDR,
	input  wire logic        CALL_PUSH,
	input  wire frame_s      PUSH_FRAME,
	input  wire logic        RET_SUB,
	input  wire logic        RET_INT,
	input  wire logic        STACK_INIT,
	input  wire logic        HALT_REQ,
	// Pin
	input  wire logic        HALT_WAKE_INPUT,
	// Decoded answers
	output logic             FETCH_VECTOR,
	output logic             ROM_OK,
	output logic             RAM_OK,
	output logic             RAM_WE,
	output region_e          RAM_REGION,
	output logic             RAM_UNDEF,
	output logic [9:0]       STACK_INDEX,
	output logic             STACK_WE,
	output logic [9:0]       STACK_ADDR,
	output logic [3:0]       STACK_DIGIT,
	output logic             RESTORE_FLAGS,
	output logic             HALTED
);
	// ----------------------------------------------------------------
	// Reset and pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_q;
	logic [1:0] wake_q;
	logic       rst_n;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_q <= 2'b00;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			wake_q <= 2'b00;
		end else begin
			wake_q <= {wake_q[0], HALT_WAKE_INPUT};
		end
	end

	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------
	function automatic region_e ram_region(input logic [9:0] a);
		if (a <= `RAM_ICB_TOP) begin
			ram_region = RG_ICB;
		end else if (a >= `RAM_FLAG_LO && a <= `RAM_FLAG_HI) begin
			ram_region = RG_FLAG;
		end else if (a <= `RAM_REGMAP_TOP) begin
			ram_region = RG_SFR;
		end else if (a <= `RAM_SCR_HI) begin
			ram_region = RG_SCR;
		end else if (a <= DATA_TOP) begin
			ram_region = RG_DATA;
		end else if (a >= `RAM_STACK_LO) begin
			ram_region = RG_STACK;
		end else begin
			ram_region = RG_HOLE;
		end
	endfunction

	function automatic logic kind_ok(input region_e r, input access_e k);
		unique case (r)
			RG_ICB, RG_FLAG: kind_ok = (k == OP_BITOP);
			RG_SFR:          kind_ok = (k == OP_DIGIT);
			RG_SCR:          kind_ok = (k == OP_SCR) || (k == OP_DIGIT);
			RG_DATA, RG_STACK: kind_ok = (k == OP_DIGIT) || (k == OP_BITOP);
			default:         kind_ok = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	state_s     s_q;
	state_s     s_d;
	region_e    reg_now;
	logic [1:0] push_cnt_q;
	logic [1:0] push_cnt_d;
	frame_s     frame_q;
	frame_s     frame_d;
	logic [3:0] digit_w;

	stack_level u_level (
		.frame    (frame_q),
		.sel      (push_cnt_q),
		.digits   (16'h0000),
		.digit    (digit_w),
		.unpacked ()
	);

	always_comb begin
		s_d        = s_q;
		push_cnt_d = push_cnt_q;
		frame_d    = frame_q;
		reg_now    = ram_region(RAM_ADDR);
		s_d.fetch_vec     = IRQ_ACK;
		s_d.rom_ok        = 1'b0;
		if (FETCH) begin
			s_d.rom_ok = (FETCH_ADDR <= ROM_TOP)
				&& (!SHORT_CALL || FETCH_ADDR <= `ROM_ZPAGE_TOP);
		end else if (TABLE_RD) begin
			s_d.rom_ok = (TABLE_ADDR <= `ROM_PATTERN_TOP);
		end
		s_d.region   = reg_now;
		s_d.ram_ok   = RAM_REQ && kind_ok(reg_now, RAM_KIND);
		s_d.ram_we   = RAM_REQ && RAM_WR && kind_ok(reg_now, RAM_KIND);
		s_d.undef_rd = RAM_REQ && !RAM_WR && (reg_now == RG_HOLE);
		s_d.restore_flags = RET_INT;
		s_d.push_we  = 1'b0;
		if (push_cnt_q != 2'b00 || s_q.push_we) begin
			s_d.push_we    = (push_cnt_q != 2'b00);
			s_d.push_digit = digit_w;
			s_d.push_addr  = s_q.stack_index - {8'h00, push_cnt_q};
			// The last write cycle only drops the strobe and holds off new stack ops
			if (push_cnt_q != 2'b00) begin
				push_cnt_d = push_cnt_q + 2'b01;
			end
			if (push_cnt_q == 2'b11) begin
				push_cnt_d = 2'b00;
				s_d.stack_index = {`STACK_FIXED,
					6'(s_q.stack_index[5:0] - `STACK_STEP)};
			end
		end else if (CALL_PUSH || IRQ_ACK) begin
			frame_d        = PUSH_FRAME;
			s_d.push_we    = 1'b1;
			s_d.push_digit = PUSH_FRAME[3:0];
			s_d.push_addr  = s_q.stack_index;
			push_cnt_d     = 2'b01;
		end else if (RET_SUB || RET_INT) begin
			s_d.stack_index = {`STACK_FIXED,
				6'(s_q.stack_index[5:0] + `STACK_STEP)};
		end
		if (STACK_INIT) begin
			s_d.stack_index = `STACK_TOP;
		end
		if (HALT_REQ) begin
			s_d.halted = 1'b1;
		end
		if (wake_q[1]) begin
			s_d.halted = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			s_q        <= '0;
			s_q.stack_index <= `STACK_TOP;
			s_q.fetch_vec   <= 1'b1;
			push_cnt_q <= 2'b00;
			frame_q    <= '0;
		end else begin
			s_q        <= s_d;
			push_cnt_q <= push_cnt_d;
			frame_q    <= frame_d;
		end
	end

	assign FETCH_VECTOR  = s_q.fetch_vec;
	assign ROM_OK        = s_q.rom_ok;
	assign RAM_OK        = s_q.ram_ok;
	assign RAM_WE        = s_q.ram_we;
	assign RAM_REGION    = region_e'(s_q.region);
	assign RAM_UNDEF     = s_q.undef_rd;
	assign STACK_INDEX   = s_q.stack_index;
	assign STACK_WE      = s_q.push_we;
	assign STACK_ADDR    = s_q.push_addr;
	assign STACK_DIGIT   = s_q.push_digit;
	assign RESTORE_FLAGS = s_q.restore_flags;
	assign HALTED        = s_q.halted;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_icb_bitonly: assert property (@(posedge CLK) disable iff (!rst_n)
		RAM_REQ && RAM_ADDR <= `RAM_ICB_TOP && RAM_KIND != OP_BITOP |=> !RAM_OK)
		else $error("interrupt bits took a non-bit access");
	a_sfr_nobit: assert property (@(posedge CLK) disable iff (!rst_n)
		RAM_REQ && RAM_ADDR >= `RAM_SFR2_LO && RAM_ADDR <= `RAM_REGMAP_TOP
		&& RAM_KIND == OP_BITOP |=> !RAM_OK)
		else $error("special register took a bit operation");
	a_flag_bitonly: assert property (@(posedge CLK) disable iff (!rst_n)
		RAM_REQ && RAM_ADDR >= `RAM_FLAG_LO && RAM_ADDR <= `RAM_FLAG_HI
		&& RAM_KIND == OP_DIGIT |=> !RAM_OK)
		else $error("flag area took a digit access");
	a_scr_ok: assert property (@(posedge CLK) disable iff (!rst_n)
		RAM_REQ && RAM_ADDR >= `RAM_SCR_LO && RAM_ADDR <= `RAM_SCR_HI
		&& RAM_KIND == OP_SCR |=> RAM_OK && RAM_REGION == RG_SCR)
		else $error("scratch access refused");
	a_hole_nowr: assert property (@(posedge CLK) disable iff (!rst_n)
		RAM_REQ && RAM_ADDR > DATA_TOP && RAM_ADDR < `RAM_STACK_LO |=> !RAM_WE)
		else $error("write reached unimplemented ram");
	a_zpage_call: assert property (@(posedge CLK) disable iff (!rst_n)
		FETCH && SHORT_CALL && FETCH_ADDR > `ROM_ZPAGE_TOP |=> !ROM_OK)
		else $error("short call left zero page");
	a_push_four: assert property (@(posedge CLK) disable iff (!rst_n)
		STACK_WE && STACK_ADDR == STACK_INDEX |=> STACK_WE [*3] ##1
		STACK_INDEX == $past(STACK_INDEX, 4) - `STACK_STEP)
		else $error("push did not write four digits");
	a_index_top: assert property (@(posedge CLK) disable iff (!rst_n)
		STACK_INDEX[9:6] == `STACK_FIXED)
		else $error("stack index left its top nibble");
	a_wake: assert property (@(posedge CLK) disable iff (!rst_n)
		wake_q[1] |=> !HALTED)
		else $error("wake did not leave stop mode");

	logic stack_idle;
	assign stack_idle = (push_cnt_q == 2'b00) && !s_q.push_we;

	a_vec_irq: assert property (@(posedge CLK) disable iff (!rst_n)
		IRQ_ACK |=> FETCH_VECTOR)
		else $error("interrupt did not select the vector region");
	a_zpage_in: assert property (@(posedge CLK) disable iff (!rst_n)
		FETCH && SHORT_CALL && FETCH_ADDR <= `ROM_ZPAGE_TOP |=> ROM_OK)
		else $error("short call inside zero page refused");
	a_table_pat: assert property (@(posedge CLK) disable iff (!rst_n)
		!FETCH && TABLE_RD && TABLE_ADDR <= `ROM_PATTERN_TOP |=> ROM_OK)
		else $error("table fetch inside pattern area refused");
	a_table_out: assert property (@(posedge CLK) disable iff (!rst_n)
		!FETCH && TABLE_RD && TABLE_ADDR > `ROM_PATTERN_TOP |=> !ROM_OK)
		else $error("table fetch outside pattern area taken");
	a_rom_in: assert property (@(posedge CLK) disable iff (!rst_n)
		FETCH && !SHORT_CALL && FETCH_ADDR <= ROM_TOP |=> ROM_OK)
		else $error("fetch inside implemented rom refused");
	a_rom_out: assert property (@(posedge CLK) disable iff (!rst_n)
		FETCH && FETCH_ADDR > ROM_TOP |=> !ROM_OK)
		else $error("fetch above implemented rom taken");
	a_regmap_low: assert property (@(posedge CLK) disable iff (!rst_n)
		RAM_REQ && RAM_ADDR <= `RAM_REGMAP_TOP |=> RAM_REGION inside {RG_ICB, RG_SFR, RG_FLAG})
		else $error("low ram address missed the register area");
	a_icb_bit: assert property (@(posedge CLK) disable iff (!rst_n)
		RAM_REQ && RAM_ADDR <= `RAM_ICB_TOP && RAM_KIND == OP_BITOP |=> RAM_OK)
		else $error("interrupt bits refused a bit operation");
	a_sfr1_nobit: assert property (@(posedge CLK) disable iff (!rst_n)
		RAM_REQ && RAM_ADDR >= `RAM_SFR1_LO && RAM_ADDR <= `RAM_SFR1_HI
		&& RAM_KIND == OP_BITOP |=> !RAM_OK)
		else $error("lower special register took a bit operation");
	a_flag_bit: assert property (@(posedge CLK) disable iff (!rst_n)
		RAM_REQ && RAM_ADDR >= `RAM_FLAG_LO && RAM_ADDR <= `RAM_FLAG_HI
		&& RAM_KIND == OP_BITOP |=> RAM_OK && RAM_REGION == RG_FLAG)
		else $error("flag area refused a bit operation");
	a_data_ok: assert property (@(posedge CLK) disable iff (!rst_n)
		RAM_REQ && RAM_ADDR >= `RAM_DATA_LO && RAM_ADDR <= DATA_TOP
		&& RAM_KIND == OP_DIGIT |=> RAM_OK && RAM_REGION == RG_DATA)
		else $error("data area refused a digit access");
	a_stack_data: assert property (@(posedge CLK) disable iff (!rst_n)
		RAM_REQ && RAM_ADDR >= `RAM_STACK_LO && RAM_KIND == OP_DIGIT
		|=> RAM_OK && RAM_REGION == RG_STACK)
		else $error("stack area refused a digit access");
	a_hole_undef: assert property (@(posedge CLK) disable iff (!rst_n)
		RAM_REQ && !RAM_WR && RAM_ADDR > DATA_TOP && RAM_ADDR < `RAM_STACK_LO |=> RAM_UNDEF)
		else $error("read of unimplemented ram not flagged");
	a_push_start: assert property (@(posedge CLK) disable iff (!rst_n)
		stack_idle && (CALL_PUSH || IRQ_ACK) |=> STACK_WE && STACK_ADDR == $past(STACK_INDEX))
		else $error("push did not start at the stack index");
	a_pop_step: assert property (@(posedge CLK) disable iff (!rst_n)
		stack_idle && !CALL_PUSH && !IRQ_ACK && (RET_SUB || RET_INT) && !STACK_INIT
		|=> STACK_INDEX[5:0] == 6'($past(STACK_INDEX) + `STACK_STEP))
		else $error("pop did not move the stack index up");
	a_ret_flags: assert property (@(posedge CLK) disable iff (!rst_n)
		RET_SUB || RET_INT |=> RESTORE_FLAGS == $past(RET_INT))
		else $error("flag restore does not match return kind");
	a_init_top: assert property (@(posedge CLK) disable iff (!rst_n)
		STACK_INIT |=> STACK_INDEX == `STACK_TOP)
		else $error("stack index not set to top");
	a_halt_enter: assert property (@(posedge CLK) disable iff (!rst_n)
		HALT_REQ && !wake_q[1] |=> HALTED)
		else $error("halt request did not enter stop mode");
endmodule

// ---- mmap_decoder_test.sv ----
// Self-checking testbench for the memory map decoder
`timescale 1ns/10ps
module mmap_decoder_test
	import mmap_pkg::*;
;
	logic CLK, RESETN, FETCH, SHORT_CALL, IRQ_ACK, TABLE_RD, RAM_REQ, RAM_WR, CALL_PUSH;
	logic RET_SUB, RET_INT, STACK_INIT, HALT_REQ, HALT_WAKE_INPUT;
	logic [13:0] FETCH_ADDR, TABLE_ADDR;
	logic [9:0]  RAM_ADDR, STACK_INDEX, STACK_ADDR;
	logic [3:0]  STACK_DIGIT;
	access_e     RAM_KIND;
	region_e     RAM_REGION;
	frame_s      PUSH_FRAME;
	logic FETCH_VECTOR, ROM_OK, RAM_OK, RAM_WE, RAM_UNDEF, STACK_WE, RESTORE_FLAGS, HALTED;
	int n_mismatch = 0;
	int num_checks = 0;

	mmap_decoder #(.ROM_TOP(14'h17ff), .DATA_TOP(10'h17f)) dut (
		.CLK(CLK), .RESETN(RESETN), .FETCH(FETCH), .FETCH_ADDR(FETCH_ADDR),
		.SHORT_CALL(SHORT_CALL), .IRQ_ACK(IRQ_ACK), .TABLE_RD(TABLE_RD),
		.TABLE_ADDR(TABLE_ADDR), .RAM_REQ(RAM_REQ), .RAM_WR(RAM_WR), .RAM_KIND(RAM_KIND),
		.RAM_ADDR(RAM_ADDR), .CALL_PUSH(CALL_PUSH), .PUSH_FRAME(PUSH_FRAME),
		.RET_SUB(RET_SUB), .RET_INT(RET_INT), .STACK_INIT(STACK_INIT), .HALT_REQ(HALT_REQ),
		.HALT_WAKE_INPUT(HALT_WAKE_INPUT), .FETCH_VECTOR(FETCH_VECTOR), .ROM_OK(ROM_OK),
		.RAM_OK(RAM_OK), .RAM_WE(RAM_WE), .RAM_REGION(RAM_REGION), .RAM_UNDEF(RAM_UNDEF),
		.STACK_INDEX(STACK_INDEX), .STACK_WE(STACK_WE), .STACK_ADDR(STACK_ADDR),
		.STACK_DIGIT(STACK_DIGIT), .RESTORE_FLAGS(RESTORE_FLAGS), .HALTED(HALTED));

	// ----------------------------------------
	// Clock
	// ----------------------------------------
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(input int n = 1);
		repeat (n) @(posedge CLK);
		#1;
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic rom(input logic sc, input logic tbl, input logic [13:0] a, input logic ok);
		FETCH = ~tbl;
		SHORT_CALL = sc;
		TABLE_RD = tbl;
		FETCH_ADDR = a;
		TABLE_ADDR = a;
		tick();
		FETCH = 1'b0;
		SHORT_CALL = 1'b0;
		TABLE_RD = 1'b0;
		chk("rom_ok", 16'(ROM_OK), 16'(ok));
		chk("fetch_vector", 16'(FETCH_VECTOR), 16'h0000);
		tick();
	endtask

	task automatic ram(input logic [9:0] a, input access_e k, input logic wr, input region_e rg,
			input logic ok);
		RAM_REQ = 1'b1;
		RAM_ADDR = a;
		RAM_KIND = k;
		RAM_WR = wr;
		tick();
		RAM_REQ = 1'b0;
		chk("ram_region", 16'(RAM_REGION), 16'(rg));
		chk("ram_undef", 16'(RAM_UNDEF), 16'((rg == RG_HOLE) && !wr));
		if (rg == RG_HOLE) begin
			chk("ram_we", 16'(RAM_WE), 16'h0000);
		end else begin
			chk("ram_ok", 16'(RAM_OK), 16'(ok));
			chk("ram_we", 16'(RAM_WE), 16'(ok && wr));
		end
		tick();
	endtask

	task automatic push_walk(input logic irq, input logic [9:0] idx, input frame_s f);
		IRQ_ACK = irq;
		CALL_PUSH = ~irq;
		PUSH_FRAME = f;
		tick();
		IRQ_ACK = 1'b0;
		CALL_PUSH = 1'b0;
		chk("fetch_vector", 16'(FETCH_VECTOR), 16'(irq));
		for (int i = 0; i < 4; i++) begin
			chk("stack_we", 16'(STACK_WE), 16'h0001);
			chk("stack_addr", 16'(STACK_ADDR), 16'(idx - 10'(i)));
			chk("stack_digit", 16'(STACK_DIGIT), 16'(f[i*4 +: 4]));
			RET_SUB = (i == 1);
			tick();
		end
		tick();
		chk("stack_we", 16'(STACK_WE), 16'h0000);
		chk("stack_index", 16'(STACK_INDEX), 16'(idx - 10'h004));
	endtask

	task automatic pop(input logic intr, input logic [9:0] idx);
		RET_INT = intr;
		RET_SUB = ~intr;
		tick();
		RET_INT = 1'b0;
		RET_SUB = 1'b0;
		chk("restore_flags", 16'(RESTORE_FLAGS), 16'(intr));
		tick();
		chk("stack_index", 16'(STACK_INDEX), 16'(idx));
	endtask

	task automatic halt_wake();
		int n;
		HALT_REQ = 1'b1;
		tick();
		HALT_REQ = 1'b0;
		tick();
		chk("halted", 16'(HALTED), 16'h0001);
		HALT_WAKE_INPUT = 1'b1;
		n = 0;
		while (HALTED !== 1'b0 && n < 8) begin
			tick();
			n++;
		end
		HALT_WAKE_INPUT = 1'b0;
		chk("wake_delay", 16'(n), 16'h0003);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{RESETN, FETCH, SHORT_CALL, IRQ_ACK, TABLE_RD, RAM_REQ, RAM_WR, CALL_PUSH} = '0;
		{RET_SUB, RET_INT, STACK_INIT, HALT_REQ, HALT_WAKE_INPUT} = '0;
		{FETCH_ADDR, TABLE_ADDR, RAM_ADDR} = '0;
		RAM_KIND = OP_NONE;
		PUSH_FRAME = '0;
		tick(20);
		chk("fetch_vector", 16'(FETCH_VECTOR), 16'h0001);
		chk("stack_index", 16'(STACK_INDEX), 16'h03ff);
		RESETN = 1'b1;
		tick(4);
		rom(1'b1, 1'b0, 14'h003f, 1'b1);
		rom(1'b1, 1'b0, 14'h0040, 1'b0);
		rom(1'b0, 1'b1, 14'h0fff, 1'b1);
		rom(1'b0, 1'b1, 14'h1000, 1'b0);
		rom(1'b0, 1'b0, 14'h17ff, 1'b1);
		rom(1'b0, 1'b0, 14'h1800, 1'b0);
		ram(10'h000, OP_BITOP, 1'b1, RG_ICB, 1'b1);
		ram(10'h003, OP_DIGIT, 1'b0, RG_ICB, 1'b0);
		ram(10'h004, OP_DIGIT, 1'b1, RG_SFR, 1'b1);
		ram(10'h01f, OP_BITOP, 1'b0, RG_SFR, 1'b0);
		ram(10'h020, OP_DIGIT, 1'b0, RG_FLAG, 1'b0);
		ram(10'h023, OP_BITOP, 1'b1, RG_FLAG, 1'b1);
		ram(10'h024, OP_BITOP, 1'b1, RG_SFR, 1'b0);
		ram(10'h03f, OP_DIGIT, 1'b0, RG_SFR, 1'b1);
		ram(10'h040, OP_SCR, 1'b0, RG_SCR, 1'b1);
		ram(10'h04f, OP_SCR, 1'b1, RG_SCR, 1'b1);
		ram(10'h050, OP_DIGIT, 1'b1, RG_DATA, 1'b1);
		ram(10'h17f, OP_BITOP, 1'b0, RG_DATA, 1'b1);
		ram(10'h180, OP_DIGIT, 1'b1, RG_HOLE, 1'b0);
		ram(10'h3bf, OP_DIGIT, 1'b0, RG_HOLE, 1'b0);
		ram(10'h3c0, OP_DIGIT, 1'b1, RG_STACK, 1'b1);
		ram(10'h3ff, OP_BITOP, 1'b0, RG_STACK, 1'b1);
		push_walk(1'b0, 10'h3ff, 16'ha5c3);
		push_walk(1'b1, 10'h3fb, 16'h3e96);
		pop(1'b1, 10'h3fb);
		pop(1'b0, 10'h3ff);
		push_walk(1'b0, 10'h3ff, 16'h0f1e);
		STACK_INIT = 1'b1;
		tick();
		STACK_INIT = 1'b0;
		tick();
		chk("stack_index", 16'(STACK_INDEX), 16'h03ff);
		halt_wake();
		final_report();
	end
endmodule

// ---- mmap_params.svh ----
// Constants for the memory map decoder
`ifndef MMAP_PARAMS_SVH
`define MMAP_PARAMS_SVH

`define ROM_VECTOR_TOP   14'h000f
`define ROM_ZPAGE_TOP    14'h003f
`define ROM_PATTERN_TOP  14'h0fff
`define ROM_TOP_DEFAULT  14'h3fff
`define RAM_REGMAP_TOP   10'h03f
`define RAM_ICB_TOP      10'h003
`define RAM_SFR1_LO      10'h004
`define RAM_SFR1_HI      10'h01f
`define RAM_FLAG_LO      10'h020
`define RAM_FLAG_HI      10'h023
`define RAM_SFR2_LO      10'h024
`define RAM_SCR_LO       10'h040
`define RAM_SCR_HI       10'h04f
`define RAM_DATA_LO      10'h050
`define RAM_DATA_TOP_DEF 10'h1ff
`define RAM_STACK_LO     10'h3c0
`define STACK_TOP        10'h3ff
`define STACK_STEP       10'h004
`define STACK_FIXED      4'hf

`endif

// ---- mmap_pkg.sv ----
// Types for the memory map decoder
package mmap_pkg;

	typedef enum logic [2:0] {
		OP_NONE  = 3'b000,
		OP_DIGIT = 3'b001,
		OP_BITOP = 3'b010,
		OP_SCR   = 3'b011,
		OP_TABLE = 3'b100
	} access_e;

	typedef enum logic [2:0] {
		RG_ICB   = 3'b000,
		RG_SFR   = 3'b001,
		RG_FLAG  = 3'b010,
		RG_SCR   = 3'b011,
		RG_DATA  = 3'b100,
		RG_STACK = 3'b101,
		RG_HOLE  = 3'b110
	} region_e;

	typedef struct packed {
		logic [13:0] pc;
		logic        branch_condition_bit;
		logic        overflow_bit;
	} frame_s;

	typedef struct packed {
		logic [9:0] stack_index;
		logic       halted;
		logic       fetch_vec;
		logic       rom_ok;
		logic       ram_ok;
		logic       ram_we;
		logic [2:0] region;
		logic       push_we;
		logic [3:0] push_digit;
		logic [9:0] push_addr;
		logic       restore_flags;
		logic       undef_rd;
	} state_s;

endpackage

// ---- stack_level.sv ----
// Splits one saved frame into four digits and packs four digits back
`timescale 1ns/10ps
module stack_level
	import mmap_pkg::*;
(
	// Frame to be saved
	input  wire frame_s     frame,
	input  wire logic [1:0] sel,
	// Digits being restored
	input  wire logic [15:0] digits,
	output logic [3:0]       digit,
	output frame_s           unpacked
);
	always_comb begin
		unique case (sel)
			2'b00: digit = frame[3:0];
			2'b01: digit = frame[7:4];
			2'b10: digit = frame[11:8];
			2'b11: digit = frame[15:12];
		endcase
	end

	assign unpacked = frame_s'(digits);
endmodule
